// File: rtl/bank_matcher.sv
// address comparator for one bank; combinational, one per bank.
// assumes the access record is stable for the cycle it is presented.
module bank_matcher
	import patch_pkg::*;
(
	input wire logic active,
	input wire logic mode_subst,
	input wire logic [ADDR_W-1:0] start,
	input wire core_access_t access,
	output logic jump_hit,
	output logic subst_hit
);

	logic addr_eq;

	assign addr_eq = active && (access.addr == start); // [RULE15] [RULE8]
	// jump only on opcode fetch at the exact start byte
	assign jump_hit = addr_eq && !mode_subst && access.kind == ACC_FETCH; // [RULE1] [RULE2]
	// pointer auto-update reads never take patched data
	assign subst_hit = addr_eq && mode_subst && access.kind == ACC_DATA && !access.ptr_update; // [RULE5] [RULE9] [RULE10]

endmodule

// File: rtl/patch_bank_store.sv
// register array holding the 24 loaded bank bytes, written one per port write.
// assumes the caller supplies the linear entry index from the write counter.
module patch_bank_store
	import patch_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic we,
	input wire logic [4:0] waddr,
	input wire logic [7:0] wdata,
	output logic [NUM_ENTRIES-1:0][7:0] entries
);

	logic [NUM_ENTRIES-1:0][7:0] entry_q;
	logic [NUM_ENTRIES-1:0][7:0] entry_d;

	for (genvar e = 0; e < NUM_ENTRIES; e++) begin : g_entry
		localparam logic [4:0] IDX = 5'(e);
		always_comb begin
			entry_d[e] = entry_q[e];
			if (we && waddr == IDX) begin
				entry_d[e] = wdata;
			end
		end
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				entry_q[e] <= ENTRY_RESET;
			end else if (ce) begin
				entry_q[e] <= entry_d[e];
			end
		end
	end

	assign entries = entry_q;

endmodule

// File: rtl/patch_pkg.sv
// constants, field layouts and carrier types for the rom patch unit.
// assumes a single 250 MHz core clock and an axi4-lite register port.
package patch_pkg;

	localparam int NUM_BANKS = 4;
	localparam int BYTES_PER_BANK = 6;
	localparam int NUM_ENTRIES = NUM_BANKS * BYTES_PER_BANK;
	localparam int ADDR_W = 20;

	// register byte offsets
	localparam logic [31:0] OFF_MODE = 32'h0000_0000;
	localparam logic [31:0] OFF_DATA = 32'h0000_0004;
	localparam logic [31:0] OFF_STATUS = 32'h0000_0008;

	// reset values and the write counter limit
	localparam logic [3:0] MODE_RESET = 4'h0;
	localparam logic [4:0] WCNT_RESET = 5'h00;
	localparam logic [4:0] WCNT_FULL = 5'h18;
	localparam logic [7:0] ENTRY_RESET = 8'h00;

	// byte order inside one bank
	localparam int IDX_START_LO = 0;
	localparam int IDX_START_MID = 1;
	localparam int IDX_START_HI = 2;
	localparam int IDX_TGT_LO = 3;
	localparam int IDX_TGT_MID = 4;
	localparam int IDX_TGT_HI = 5;

	// status register fields
	localparam int ST_EN_BIT = 0;
	localparam int ST_WCNT_LSB = 8;
	localparam int ST_LOADED_LSB = 16;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ACC_NONE = 2'b00,
		ACC_FETCH = 2'b01,
		ACC_DATA = 2'b10
	} acc_kind_t;

	typedef enum logic [1:0] {
		SZ_1 = 2'b01,
		SZ_2 = 2'b10,
		SZ_3 = 2'b11
	} acc_size_t;

	typedef struct packed {
		acc_kind_t kind;
		acc_size_t size;
		logic ptr_update;
		logic [ADDR_W-1:0] addr;
	} core_access_t;

	typedef struct packed {
		logic valid;
		logic [ADDR_W-1:0] target;
	} jump_t;

	typedef struct packed {
		logic valid;
		logic [2:0] mask;
		logic [23:0] data;
	} subst_t;

	typedef struct packed {
		logic awvalid;
		logic [31:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [31:0] araddr;
		logic rready;
	} axil_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axil_rsp_t;

endpackage

// File: rtl/rom_patch_unit.sv
// rom patch unit: four banks that redirect fetches or substitute rom data.
// assumes the core presents one access per cycle on the core clock and
// takes the registered jump/substitution answer one cycle later.
//
// The implementer's own choices: the address map and the AXI4-Lite slave port.

// Summary of operation
// [RULE1] mode bit zero makes the bank a program jump bank.
// [RULE2] fetch at the bank start address yields a jump to the bank target.
// [RULE3] software sets jump match addresses on an instruction's first byte only.
// [RULE4] patch routines in ram end with a jump back into rom.
// [RULE5] mode bit one makes the bank a data substitution bank.
// [RULE6] substitution bank holds three bytes for start and next two addresses.
// [RULE7] one-byte read gets first byte; two-byte read gets first two bytes.
// [RULE8] reads starting anywhere but the start address return plain rom.
// [RULE9] only constant data reads are substituted, never opcode or operand fetches.
// [RULE10] pointer post-increment or pre-decrement reads are never substituted.
// [RULE11] each bank picks its mode with its own mode bit.
// [RULE12] every data port write advances the write counter; reset clears it. Here the counter stops at 24 and later writes leave it.
// [RULE13] bank bytes load as start lo, mid, hi nibble, then target lo, mid, hi.
// [RULE14] patching off after reset, on once one bank loads, off only by reset.
// [RULE15] full 20-bit address compared against every loaded bank each cycle.
module rom_patch_unit
	import patch_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire axil_req_t axi_req,
	output axil_rsp_t axi_rsp,
	input wire core_access_t access,
	output jump_t jump,
	output subst_t subst
);

	// axi write side
	logic aw_have_q;
	logic aw_have_d;
	logic [31:0] aw_addr_q;
	logic [31:0] aw_addr_d;
	logic w_have_q;
	logic w_have_d;
	logic [31:0] w_data_q;
	logic [31:0] w_data_d;
	logic [3:0] w_strb_q;
	logic [3:0] w_strb_d;
	logic bvalid_q;
	logic bvalid_d;
	logic [1:0] bresp_q;
	logic [1:0] bresp_d;

	// axi read side
	logic rvalid_q;
	logic rvalid_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [1:0] rresp_q;
	logic [1:0] rresp_d;

	// patch control state
	logic [3:0] mode_q;
	logic [3:0] mode_d;
	logic [4:0] wcnt_q;
	logic [4:0] wcnt_d;
	logic en_q;
	logic en_d;

	// registered answers to the core
	jump_t jump_q;
	jump_t jump_d;
	subst_t subst_q;
	subst_t subst_d;

	logic awready;
	logic wready;
	logic arready;
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic do_write;
	logic [31:0] wr_word_addr;
	logic [31:0] rd_word_addr;
	logic store_we;
	logic [31:0] status_word;

	logic [NUM_ENTRIES-1:0][7:0] entries;
	logic [NUM_BANKS-1:0] bank_loaded;
	logic [NUM_BANKS-1:0] jump_hit;
	logic [NUM_BANKS-1:0] subst_hit;
	logic [NUM_BANKS-1:0][ADDR_W-1:0] bank_start;
	logic [NUM_BANKS-1:0][ADDR_W-1:0] bank_target;
	logic [NUM_BANKS-1:0][23:0] bank_bytes;

	// ---- axi4-lite handshakes ----
	// one write in flight: no new address or data until the response is taken
	assign awready = ce && !aw_have_q && !bvalid_q;
	assign wready = ce && !w_have_q && !bvalid_q;
	assign arready = ce && !rvalid_q;
	assign aw_take = axi_req.awvalid && awready;
	assign w_take = axi_req.wvalid && wready;
	assign ar_take = axi_req.arvalid && arready;
	assign do_write = aw_have_q && w_have_q && !bvalid_q;
	assign wr_word_addr = {aw_addr_q[31:2], 2'b00};
	assign rd_word_addr = {axi_req.araddr[31:2], 2'b00};

	// saturating counter: writes past the last bank byte store nothing
	assign store_we = do_write && wr_word_addr == OFF_DATA && w_strb_q[0] && wcnt_q != WCNT_FULL; // [RULE12]

	always_comb begin
		aw_have_d = aw_have_q;
		aw_addr_d = aw_addr_q;
		w_have_d = w_have_q;
		w_data_d = w_data_q;
		w_strb_d = w_strb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		mode_d = mode_q;
		wcnt_d = wcnt_q;
		if (aw_take) begin
			aw_have_d = 1'b1;
			aw_addr_d = axi_req.awaddr;
		end
		if (w_take) begin
			w_have_d = 1'b1;
			w_data_d = axi_req.wdata;
			w_strb_d = axi_req.wstrb;
		end
		if (do_write) begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = RESP_OKAY;
			if (wr_word_addr == OFF_MODE) begin
				if (w_strb_q[0]) begin
					mode_d = w_data_q[3:0]; // [RULE11]
				end
			end else if (wr_word_addr == OFF_DATA) begin
				if (store_we) begin
					wcnt_d = wcnt_q + 5'h01; // [RULE12] [RULE13]
				end
			end else if (wr_word_addr == OFF_STATUS) begin
				bresp_d = RESP_OKAY;
			end else begin
				bresp_d = RESP_SLVERR;
			end
		end else if (bvalid_q && axi_req.bready) begin
			bvalid_d = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= 32'h0000_0000;
			w_have_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			mode_q <= MODE_RESET;
			wcnt_q <= WCNT_RESET; // [RULE12]
		end else if (ce) begin
			aw_have_q <= aw_have_d;
			aw_addr_q <= aw_addr_d;
			w_have_q <= w_have_d;
			w_data_q <= w_data_d;
			w_strb_q <= w_strb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			mode_q <= mode_d;
			wcnt_q <= wcnt_d;
		end
	end

	// ---- read path ----
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[ST_EN_BIT] = en_q;
		status_word[ST_WCNT_LSB +: 5] = wcnt_q;
		status_word[ST_LOADED_LSB +: NUM_BANKS] = bank_loaded;
	end

	always_comb begin
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (ar_take) begin
			rvalid_d = 1'b1;
			rresp_d = RESP_OKAY;
			if (rd_word_addr == OFF_MODE) begin
				rdata_d = {28'h000_0000, mode_q};
			end else if (rd_word_addr == OFF_DATA) begin
				// data port is write only
				rdata_d = 32'h0000_0000;
			end else if (rd_word_addr == OFF_STATUS) begin
				rdata_d = status_word;
			end else begin
				rdata_d = 32'h0000_0000;
				rresp_d = RESP_SLVERR;
			end
		end else if (rvalid_q && axi_req.rready) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OKAY;
		end else if (ce) begin
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	always_comb begin
		axi_rsp.awready = awready;
		axi_rsp.wready = wready;
		axi_rsp.bvalid = bvalid_q;
		axi_rsp.bresp = bresp_q;
		axi_rsp.arready = arready;
		axi_rsp.rvalid = rvalid_q;
		axi_rsp.rdata = rdata_q;
		axi_rsp.rresp = rresp_q;
	end

	// ---- bank storage and comparison ----
	patch_bank_store u_store (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.we(store_we),
		.waddr(wcnt_q), // [RULE13]
		.wdata(w_data_q[7:0]),
		.entries(entries)
	);

	for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
		localparam int BASE = b * BYTES_PER_BANK;
		localparam logic [4:0] LOADED_AT = 5'((b + 1) * BYTES_PER_BANK);

		// a half-loaded bank never matches
		assign bank_loaded[b] = wcnt_q >= LOADED_AT;
		// start and jump address upper bytes carry only four bits
		assign bank_start[b] = {entries[BASE + IDX_START_HI][3:0], entries[BASE + IDX_START_MID],
			entries[BASE + IDX_START_LO]}; // [RULE13]
		assign bank_target[b] = {entries[BASE + IDX_TGT_HI][3:0], entries[BASE + IDX_TGT_MID],
			entries[BASE + IDX_TGT_LO]};
		assign bank_bytes[b] = {entries[BASE + IDX_TGT_HI], entries[BASE + IDX_TGT_MID],
			entries[BASE + IDX_TGT_LO]}; // [RULE6]

		bank_matcher u_match (
			.active(en_q && bank_loaded[b]), // [RULE14]
			.mode_subst(mode_q[b]), // [RULE11]
			.start(bank_start[b]),
			.access(access),
			.jump_hit(jump_hit[b]),
			.subst_hit(subst_hit[b])
		);
	end

	// enable is sticky: only reset clears it
	assign en_d = en_q || bank_loaded[0]; // [RULE14]

	// ---- answer to the core, lowest bank wins on overlap ----
	always_comb begin
		jump_d = '0;
		subst_d = '0;
		for (int b = NUM_BANKS - 1; b >= 0; b--) begin
			if (jump_hit[b]) begin
				jump_d.valid = 1'b1;
				jump_d.target = bank_target[b]; // [RULE2]
			end
			if (subst_hit[b]) begin
				subst_d.valid = 1'b1;
				subst_d.data = bank_bytes[b]; // [RULE6]
				case (access.size)
					SZ_1: subst_d.mask = 3'b001; // [RULE7]
					SZ_2: subst_d.mask = 3'b011; // [RULE7]
					SZ_3: subst_d.mask = 3'b111; // [RULE6]
					default: subst_d.mask = 3'b000;
				endcase
				if (subst_d.mask == 3'b000) begin
					subst_d.valid = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			en_q <= 1'b0; // [RULE14]
			jump_q <= '0;
			subst_q <= '0;
		end else if (ce) begin
			en_q <= en_d;
			jump_q <= jump_d;
			subst_q <= subst_d;
		end
	end

	assign jump = jump_q;
	assign subst = subst_q;

endmodule

// File: tb/core_model.sv
// core fetch and data read path with a small synthetic rom image.
// assumes the unit answers exactly one cycle after an access.
module core_model
	import patch_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic go,
	input wire core_access_t req,
	input wire jump_t jump,
	input wire subst_t subst,
	output core_access_t access,
	output logic [23:0] rd_data,
	output logic [ADDR_W-1:0] next_pc
);
	timeunit 1ns;
	timeprecision 1ps;
	core_access_t access_d;
	core_access_t last_q;
	always_comb begin
		access_d = go ? req : '0;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			access <= '0;
			last_q <= '0;
		end else begin
			access <= access_d;
			last_q <= access;
		end
	end
	// rom bytes fold the address so neighbours always differ
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			rd_data[i*8 +: 8] = (last_q.addr[7:0] + 8'(i)) ^ 8'ha5;
			if (subst.valid && subst.mask[i]) rd_data[i*8 +: 8] = subst.data[i*8 +: 8];
		end
		next_pc = jump.valid ? jump.target : last_q.addr + 20'h0_0001;
	end
endmodule

// File: tb/patch_chk.sv
// assertions on the patch unit's core answer and register bus timing.
// assumes one clock domain and an async active-low reset.
module patch_chk
	import patch_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire axil_req_t axi_req,
	input wire axil_rsp_t axi_rsp,
	input wire core_access_t access,
	input wire jump_t jump,
	input wire subst_t subst
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_wr_taken;
		ce && axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
	endsequence
	property p_wr_resp; s_wr_taken ##1 ce |=> axi_rsp.bvalid; endproperty
	property p_rd_resp; ce && axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid; endproperty
	property p_ar_block; axi_rsp.rvalid |-> !axi_rsp.arready; endproperty
	property p_aw_block; axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready; endproperty
	property p_jump_src; $past(ce) && jump.valid |-> $past(access.kind) == ACC_FETCH; endproperty
	property p_subst_src;
		$past(ce) && subst.valid |-> $past(access.kind) == ACC_DATA && !$past(access.ptr_update);
	endproperty
	property p_mask;
		$past(ce) && subst.valid |-> subst.mask == {$past(access.size) == SZ_3, $past(access.size) != SZ_1, 1'b1};
	endproperty
	property p_idle; ce && access.kind == ACC_NONE |=> !jump.valid && !subst.valid; endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("late write response");
	a_rd_resp: assert property (p_rd_resp) else $error("late read response");
	a_ar_block: assert property (p_ar_block) else $error("read taken while answer pending");
	a_aw_block: assert property (p_aw_block) else $error("write taken while answer pending");
	a_jump_src: assert property (p_jump_src) else $error("jump without fetch");
	a_subst_src: assert property (p_subst_src) else $error("bad substitution source");
	a_mask: assert property (p_mask) else $error("mask does not follow size");
	a_idle: assert property (p_idle) else $error("answer without access");
endmodule
bind rom_patch_unit patch_chk patch_chk_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .axi_req(axi_req),
	.axi_rsp(axi_rsp), .access(access), .jump(jump), .subst(subst));

// File: tb/rom_patch_unit_tb.sv
// bench: loads four banks over the register bus, then checks fetches and reads.
// assumes the unit answers core accesses one cycle late and ce held high.
module rom_patch_unit_tb import patch_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
		$display("FAIL %s exp %h got %h", nm, e, g); end end
	localparam logic [19:0] B1 = 20'h1_c030;
	logic clk, rst_n, ce, go;
	axil_req_t axi_req;
	axil_rsp_t axi_rsp;
	core_access_t req, access;
	jump_t jump;
	subst_t subst;
	logic [23:0] rd_data;
	logic [19:0] next_pc;
	logic [31:0] rdat;
	logic [1:0] resp;
	int num_errors, num_checks;
	logic [7:0] load [24] = '{8'h20, 8'hc0, 8'h00, 8'h00, 8'h04, 8'h00, 8'h30, 8'hc0, 8'h01, 8'h33, 8'hcc, 8'hc3,
		8'hfe, 8'hff, 8'h0f, 8'h45, 8'h23, 8'h01, 8'h05, 8'h00, 8'h00, 8'h11, 8'h22, 8'hf3};
	rom_patch_unit rom_patch_unit_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .axi_req(axi_req), .axi_rsp(axi_rsp),
		.access(access), .jump(jump), .subst(subst));
	core_model core_model_inst (.clk(clk), .rst_n(rst_n), .go(go), .req(req), .jump(jump), .subst(subst),
		.access(access), .rd_data(rd_data), .next_pc(next_pc));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	function automatic logic [23:0] r3(input logic [19:0] a);
		r3 = {a[7:0] + 8'h02, a[7:0] + 8'h01, a[7:0]} ^ 24'ha5_a5a5;
	endfunction
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic hang();
		num_errors++;
		$display("FAIL bus handshake exp 1 got 0");
		wrap_up();
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		axi_req.awaddr <= a;
		axi_req.wdata <= d;
		axi_req.wstrb <= 4'hf;
		axi_req.awvalid <= 1'b1;
		axi_req.wvalid <= 1'b1;
		axi_req.bready <= 1'b1;
		repeat (20) begin
			@(posedge clk);
			if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
			if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
			if (axi_rsp.bvalid) break;
		end
		axi_req.bready <= 1'b0;
		resp = axi_rsp.bresp;
		if (!axi_rsp.bvalid) hang();
	endtask
	task automatic rd(input logic [31:0] a);
		@(posedge clk);
		axi_req.araddr <= a;
		axi_req.arvalid <= 1'b1;
		axi_req.rready <= 1'b1;
		repeat (20) begin
			@(posedge clk);
			if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
			if (axi_rsp.rvalid) break;
		end
		axi_req.rready <= 1'b0;
		rdat = axi_rsp.rdata;
		resp = axi_rsp.rresp;
		if (!axi_rsp.rvalid) hang();
	endtask
	task automatic acc(input acc_kind_t k, input acc_size_t s, input logic p, input logic [19:0] a,
		input logic [23:0] ed, input logic [19:0] ep);
		@(posedge clk);
		go <= 1'b1;
		req <= '{kind: k, size: s, ptr_update: p, addr: a};
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		`CHK("read data", ed, rd_data)
		`CHK("next pc", ep, next_pc)
	endtask
	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		go = 1'b0;
		req = '0;
		axi_req = '0;
		num_errors = 0;
		num_checks = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rd(OFF_STATUS);
		`CHK("status after reset", 32'h0000_0000, rdat)
		$display("test reset done");
		wr(OFF_MODE, 32'h0000_000a);
		rd(OFF_MODE);
		`CHK("mode readback", 32'h0000_000a, rdat)
		for (int i = 0; i < 24; i++) begin
			wr(OFF_DATA, {24'h00_0000, load[i]});
			if (i == 4) acc(ACC_FETCH, SZ_1, 1'b0, 20'h0_c020, r3(20'h0_c020), 20'h0_c021);
			if (i == 5) rd(OFF_STATUS);
			if (i == 5) `CHK("status one bank", 32'h0001_0601, rdat)
		end
		wr(OFF_DATA, 32'h0000_0077);
		`CHK("ignored write resp", RESP_OKAY, resp)
		rd(OFF_STATUS);
		`CHK("status full", 32'h000f_1801, rdat)
		wr(32'h0000_0010, 32'h0000_0000);
		`CHK("unmapped write resp", RESP_SLVERR, resp)
		rd(32'h0000_0010);
		`CHK("unmapped resp", RESP_SLVERR, resp)
		$display("test load done");
		acc(ACC_FETCH, SZ_1, 1'b0, 20'h0_c020, r3(20'h0_c020), 20'h0_0400);
		// patch routine body in ram runs unpatched until its closing jump
		acc(ACC_FETCH, SZ_1, 1'b0, 20'h0_0400, r3(20'h0_0400), 20'h0_0401);
		acc(ACC_FETCH, SZ_1, 1'b0, 20'h0_c021, r3(20'h0_c021), 20'h0_c022);
		acc(ACC_DATA, SZ_3, 1'b0, 20'h0_c020, r3(20'h0_c020), 20'h0_c021);
		acc(ACC_DATA, SZ_1, 1'b0, B1, r3(B1) & 24'hff_ff00 | 24'h00_0033, 20'h1_c031);
		acc(ACC_DATA, SZ_2, 1'b0, B1, r3(B1) & 24'hff_0000 | 24'h00_cc33, 20'h1_c031);
		acc(ACC_DATA, SZ_3, 1'b0, B1, 24'hc3_cc33, 20'h1_c031);
		acc(ACC_DATA, SZ_3, 1'b0, 20'h1_c031, r3(20'h1_c031), 20'h1_c032);
		acc(ACC_FETCH, SZ_1, 1'b0, B1, r3(B1), 20'h1_c031);
		acc(ACC_DATA, SZ_3, 1'b1, B1, r3(B1), 20'h1_c031);
		acc(ACC_FETCH, SZ_1, 1'b0, 20'hf_fffe, r3(20'hf_fffe), 20'h1_2345);
		acc(ACC_FETCH, SZ_1, 1'b0, 20'h7_fffe, r3(20'h7_fffe), 20'h7_ffff);
		acc(ACC_DATA, SZ_3, 1'b0, 20'h0_0005, 24'hf3_2211, 20'h0_0006);
		$display("test match done");
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(OFF_STATUS);
		`CHK("status second reset", 32'h0000_0000, rdat)
		acc(ACC_FETCH, SZ_1, 1'b0, 20'h0_c020, r3(20'h0_c020), 20'h0_c021);
		$display("test second reset done");
		wrap_up();
	end
endmodule
